/* File: hw/bbg_pkg.sv */
`default_nettype none
package bbg_pkg;
    // width of the multi-input gates
    localparam int unsigned BBG_WIDE_N    = 4;
    // width of the exclusive-or gate
    localparam int unsigned BBG_XOR_N     = 2;
    // levels taken by unconnected inputs
    localparam logic        BBG_AND_UNUSED = 1'b1;
    localparam logic        BBG_OR_UNUSED  = 1'b0;
    // reset value of the previous-cycle input store: all high, so no false AND edge from reset; NAND pulses if inputs start not all high
    localparam logic [BBG_WIDE_N-1:0] BBG_PREV_RST = 4'hF;
endpackage
`default_nettype wire

/* File: hw/bbg_edge_if.sv */
`timescale 1ns/1ps
`default_nettype none
// carries the conditioned conjunction inputs into the edge stage and its pulses back
interface bbg_edge_if;
    import bbg_pkg::*;
    logic [BBG_WIDE_N-1:0] and_in;
    logic [BBG_WIDE_N-1:0] nand_in;
    logic                  and_pulse;
    logic                  nand_pulse;
    modport core (output and_in, output nand_in, input and_pulse, input nand_pulse);
    modport edge_stage (input and_in, input nand_in, output and_pulse, output nand_pulse);
endinterface
`default_nettype wire

/* File: hw/bbg_edge_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module bbg_edge_stage
    import bbg_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     rst_n_i,
    input  wire logic     ce_i,
    bbg_edge_if.edge_stage e
);
    logic [BBG_WIDE_N-1:0] and_prev_reg,  and_prev_next;
    logic [BBG_WIDE_N-1:0] nand_prev_reg, nand_prev_next;
    logic                  and_q_reg,     and_q_next;
    logic                  nand_q_reg,    nand_q_next;

    // pulses fire on the transition into / out of the all-high state
    always_comb begin
        and_prev_next  = e.and_in;
        nand_prev_next = e.nand_in;
        and_q_next     = (&e.and_in) && !(&and_prev_reg);
        nand_q_next    = !(&e.nand_in) && (&nand_prev_reg);
    end

    // a new edge needs a low cycle in between, so a pulse never lasts two enabled cycles
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            and_prev_reg  <= BBG_PREV_RST;
            nand_prev_reg <= BBG_PREV_RST;
            and_q_reg     <= 1'b0;
            nand_q_reg    <= 1'b0;
        end else if (ce_i) begin
            and_prev_reg  <= and_prev_next;
            nand_prev_reg <= nand_prev_next;
            and_q_reg     <= and_q_next;
            nand_q_reg    <= nand_q_next;
        end
    end

    assign e.and_pulse  = and_q_reg;
    assign e.nand_pulse = nand_q_reg;
endmodule
`default_nettype wire

/* File: hw/bbg_gates.sv */
// Summary of operation
// - AND output high only when all high
// - edge AND fires when all high, was not
// - edge AND pulse one enabled cycle, then low
// - unused AND/NAND inputs read as high
// - NAND output low only when all high
// - edge NAND pulse one enabled cycle, then low
// - OR output high when any input high
// - unused OR/NOR/XOR inputs read as low
// - NOR output high only when all low
// - XOR output high when inputs differ
// - NOT outputs complement of its input
// - per-input optional inversion on every gate
`timescale 1ns/1ps
`default_nettype none
module bbg_gates
    import bbg_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  ce_i,
    input  wire logic [BBG_WIDE_N-1:0] and_in_i,
    input  wire logic [BBG_WIDE_N-1:0] and_used_i,
    input  wire logic [BBG_WIDE_N-1:0] and_inv_i,
    input  wire logic [BBG_WIDE_N-1:0] nand_in_i,
    input  wire logic [BBG_WIDE_N-1:0] nand_used_i,
    input  wire logic [BBG_WIDE_N-1:0] nand_inv_i,
    input  wire logic [BBG_WIDE_N-1:0] or_in_i,
    input  wire logic [BBG_WIDE_N-1:0] or_used_i,
    input  wire logic [BBG_WIDE_N-1:0] or_inv_i,
    input  wire logic [BBG_WIDE_N-1:0] nor_in_i,
    input  wire logic [BBG_WIDE_N-1:0] nor_used_i,
    input  wire logic [BBG_WIDE_N-1:0] nor_inv_i,
    input  wire logic [BBG_XOR_N-1:0]  xor_in_i,
    input  wire logic [BBG_XOR_N-1:0]  xor_used_i,
    input  wire logic [BBG_XOR_N-1:0]  xor_inv_i,
    input  wire logic                  not_in_i,
    input  wire logic                  not_inv_i,
    output logic                       and_o,
    output logic                       and_edge_o,
    output logic                       nand_o,
    output logic                       nand_edge_o,
    output logic                       or_o,
    output logic                       nor_o,
    output logic                       xor_o,
    output logic                       not_o
);
    logic                  rst_meta_reg;
    logic                  rst_sync_reg;
    logic [BBG_WIDE_N-1:0] and_c, nand_c, or_c, nor_c;
    logic [BBG_XOR_N-1:0]  xor_c;
    logic                  not_c;
    logic                  and_reg,  and_next;
    logic                  nand_reg, nand_next;
    logic                  or_reg,   or_next;
    logic                  nor_reg,  nor_next;
    logic                  xor_reg,  xor_next;
    logic                  not_reg,  not_next;

    bbg_edge_if edge_bus ();

    // reset release passes two flops; assertion stays asynchronous
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // inputs come from same-clock logic, so no synchroniser; per-bit default then inversion
    genvar gi;
    generate
        for (gi = 0; gi < BBG_WIDE_N; gi++) begin : g_wide
            assign and_c[gi]  = (and_used_i[gi]  ? and_in_i[gi]  : BBG_AND_UNUSED) ^ and_inv_i[gi];
            assign nand_c[gi] = (nand_used_i[gi] ? nand_in_i[gi] : BBG_AND_UNUSED) ^ nand_inv_i[gi];
            assign or_c[gi]   = (or_used_i[gi]   ? or_in_i[gi]   : BBG_OR_UNUSED)  ^ or_inv_i[gi];
            assign nor_c[gi]  = (nor_used_i[gi]  ? nor_in_i[gi]  : BBG_OR_UNUSED)  ^ nor_inv_i[gi];
        end
        for (gi = 0; gi < BBG_XOR_N; gi++) begin : g_xor
            assign xor_c[gi] = (xor_used_i[gi] ? xor_in_i[gi] : BBG_OR_UNUSED) ^ xor_inv_i[gi];
        end
    endgenerate
    assign not_c = not_in_i ^ not_inv_i;

    // inverted-unused inputs flip too; that matches an inverted constant input
    assign edge_bus.and_in  = and_c;
    assign edge_bus.nand_in = nand_c;

    // gate evaluation, once per program cycle
    always_comb begin
        and_next  = &and_c;
        nand_next = ~&nand_c;
        or_next   = |or_c;
        nor_next  = ~|nor_c;
        xor_next  = ^xor_c;
        not_next  = ~not_c;
    end

    // registered outputs: one cycle of latency, same as the edge pulses
    always_ff @(posedge clk_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            and_reg  <= 1'b0;
            nand_reg <= 1'b0;
            or_reg   <= 1'b0;
            nor_reg  <= 1'b0;
            xor_reg  <= 1'b0;
            not_reg  <= 1'b0;
        end else if (ce_i) begin
            and_reg  <= and_next;
            nand_reg <= nand_next;
            or_reg   <= or_next;
            nor_reg  <= nor_next;
            xor_reg  <= xor_next;
            not_reg  <= not_next;
        end
    end

    bbg_edge_stage u_edge (
        .clk_i   (clk_i),
        .rst_n_i (rst_sync_reg),
        .ce_i    (ce_i),
        .e       (edge_bus.edge_stage)
    );

    assign and_o       = and_reg;
    assign nand_o      = nand_reg;
    assign or_o        = or_reg;
    assign nor_o       = nor_reg;
    assign xor_o       = xor_reg;
    assign not_o       = not_reg;
    assign and_edge_o  = edge_bus.and_pulse;
    assign nand_edge_o = edge_bus.nand_pulse;
endmodule
`default_nettype wire

/* File: tb/bbg_gates_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module bbg_gates_chk
    import bbg_pkg::*;
(
    input wire logic                  clk_i,
    input wire logic                  reset_n_i,
    input wire logic                  ce_i,
    input wire logic [BBG_WIDE_N-1:0] and_in_i,
    input wire logic [BBG_WIDE_N-1:0] and_used_i,
    input wire logic [BBG_WIDE_N-1:0] and_inv_i,
    input wire logic [BBG_WIDE_N-1:0] nand_in_i,
    input wire logic [BBG_WIDE_N-1:0] nand_used_i,
    input wire logic [BBG_WIDE_N-1:0] nand_inv_i,
    input wire logic [BBG_WIDE_N-1:0] or_in_i,
    input wire logic [BBG_WIDE_N-1:0] or_used_i,
    input wire logic [BBG_WIDE_N-1:0] or_inv_i,
    input wire logic [BBG_WIDE_N-1:0] nor_in_i,
    input wire logic [BBG_WIDE_N-1:0] nor_used_i,
    input wire logic [BBG_WIDE_N-1:0] nor_inv_i,
    input wire logic [BBG_XOR_N-1:0]  xor_in_i,
    input wire logic [BBG_XOR_N-1:0]  xor_used_i,
    input wire logic [BBG_XOR_N-1:0]  xor_inv_i,
    input wire logic                  not_in_i,
    input wire logic                  not_inv_i,
    input wire logic                  and_o,
    input wire logic                  and_edge_o,
    input wire logic                  nand_o,
    input wire logic                  nand_edge_o,
    input wire logic                  or_o,
    input wire logic                  nor_o,
    input wire logic                  xor_o,
    input wire logic                  not_o
);
    logic [2:0]            up_reg;
    logic [BBG_WIDE_N-1:0] ca, cn, co, cr;
    logic [BBG_XOR_N-1:0]  cx;
    // inputs after default substitution, then inversion
    assign ca = (and_in_i | ~and_used_i) ^ and_inv_i;
    assign cn = (nand_in_i | ~nand_used_i) ^ nand_inv_i;
    assign co = (or_in_i & or_used_i) ^ or_inv_i;
    assign cr = (nor_in_i & nor_used_i) ^ nor_inv_i;
    assign cx = (xor_in_i & xor_used_i) ^ xor_inv_i;
    // edges since release; the internal reset copy lags, so checks wait until it has settled
    always_ff @(posedge clk_i or negedge reset_n_i)
        if (!reset_n_i) up_reg <= 3'h0;
        else if (up_reg != 3'h5) up_reg <= up_reg + 3'h1;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i || up_reg != 3'h5);
    property p_and; ce_i |=> and_o == &$past(ca); endproperty
    a_and: assert property (p_and) else $error("and output wrong");
    property p_nand; ce_i |=> nand_o == !(&$past(cn)); endproperty
    a_nand: assert property (p_nand) else $error("nand output wrong");
    property p_or; ce_i |=> or_o == |$past(co); endproperty
    a_or: assert property (p_or) else $error("or output wrong");
    property p_nor; ce_i |=> nor_o == !(|$past(cr)); endproperty
    a_nor: assert property (p_nor) else $error("nor output wrong");
    property p_xor; ce_i |=> xor_o == ^$past(cx); endproperty
    a_xor: assert property (p_xor) else $error("xor output wrong");
    property p_not; ce_i |=> not_o == !$past(not_in_i ^ not_inv_i); endproperty
    a_not: assert property (p_not) else $error("not output wrong");
    property p_ande; ce_i && $past(ce_i) |=> and_edge_o == (&$past(ca) && !(&$past(ca, 2))); endproperty
    a_ande: assert property (p_ande) else $error("and pulse wrong");
    property p_nande; ce_i && $past(ce_i) |=> nand_edge_o == (!(&$past(cn)) && &$past(cn, 2)); endproperty
    a_nande: assert property (p_nande) else $error("nand pulse wrong");
    property p_apulse; and_edge_o && ce_i |=> !and_edge_o; endproperty
    a_apulse: assert property (p_apulse) else $error("and pulse too long");
    property p_npulse; nand_edge_o && ce_i |=> !nand_edge_o; endproperty
    a_npulse: assert property (p_npulse) else $error("nand pulse too long");
endmodule
bind bbg_gates bbg_gates_chk chk_u (.*);
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bbg_pkg::*;
    logic                  clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1;
    logic [BBG_WIDE_N-1:0] ai = '0, au = '0, av = '0, oi = '0, ou = '0, ov = '0;
    logic                  and_o, and_edge_o, nand_o, nand_edge_o, or_o, nor_o, xor_o, not_o;
    int                    num_errors = 0, total_checks = 0;
    always #2.5 clk_i = ~clk_i;
    // and/nand share one input set, or/nor/xor/not another, so one step exercises all gates
    bbg_gates dut_u (.clk_i, .reset_n_i, .ce_i, .and_in_i(ai), .and_used_i(au), .and_inv_i(av),
        .nand_in_i(ai), .nand_used_i(au), .nand_inv_i(av), .or_in_i(oi), .or_used_i(ou), .or_inv_i(ov),
        .nor_in_i(oi), .nor_used_i(ou), .nor_inv_i(ov), .xor_in_i(oi[1:0]), .xor_used_i(ou[1:0]),
        .xor_inv_i(ov[1:0]), .not_in_i(oi[0]), .not_inv_i(ov[0]), .and_o, .and_edge_o, .nand_o,
        .nand_edge_o, .or_o, .nor_o, .xor_o, .not_o);
    task chk(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %b, wanted %b", $time, got, exp);
        end
    endtask
    // drive at a falling edge, result is settled by the next one
    task step(input logic [3:0] a_i, a_u, a_v, o_i, o_u, o_v);
        {ai, au, av, oi, ou, ov} = {a_i, a_u, a_v, o_i, o_u, o_v};
        @(negedge clk_i);
    endtask
    // three ways of reaching the same effective inputs: direct, unused defaults, inversion
    task test_gates;
        logic [3:0] e;
        for (int m = 0; m < 3; m++) begin
            for (int i = 0; i < 16; i++) begin
                e = 4'(i);
                if (m == 0) step(e, 4'hF, 4'h0, e, 4'hF, 4'h0);
                else if (m == 1) step(4'h0, ~e, 4'h0, 4'hF, e, 4'h0);
                else step(~e, 4'hF, 4'hF, ~e, 4'hF, 4'hF);
                chk(and_o, &e);
                chk(nand_o, ~&e);
                chk(or_o, |e);
                chk(nor_o, ~|e);
                chk(xor_o, ^e[1:0]);
                chk(not_o, ~(oi[0] ^ ov[0]));
            end
        end
        $display("test_gates done");
    endtask
    task edg(input logic [3:0] e, input logic xa, input logic xn);
        step(e, 4'hF, 4'h0, 4'h0, 4'h0, 4'h0);
        chk(and_edge_o, xa);
        chk(nand_edge_o, xn);
    endtask
    // starts from all-high inputs left by test_gates
    task test_edge;
        edg(4'hE, 1'b0, 1'b1);
        edg(4'hE, 1'b0, 1'b0);
        edg(4'hF, 1'b1, 1'b0);
        edg(4'hF, 1'b0, 1'b0);
        edg(4'h0, 1'b0, 1'b1);
        edg(4'hF, 1'b1, 1'b0);
        $display("test_edge done");
    endtask
    // with the enable low nothing moves, not even the edge store
    task test_ce;
        ce_i = 1'b0;
        edg(4'h0, 1'b1, 1'b0);
        edg(4'h0, 1'b1, 1'b0);
        chk(and_o, 1'b1);
        ce_i = 1'b1;
        edg(4'h0, 1'b0, 1'b1);
        $display("test_ce done");
    endtask
    task complete_run;
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        test_gates;
        test_edge;
        test_ce;
        complete_run;
    end
endmodule
`default_nettype wire
